/* include/nvc_pkg.sv */
// Purpose: constants for the calibration non-volatile programmer
// Assumes: 20 MHz system clock, 8-bit register addresses from the serial slave
// Notes: timing counts derive from the printed times and the clock rate
package nvc_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam logic [7:0]  CAL_FIRST_ADDR  = 8'h07;
  localparam logic [7:0]  CAL_LAST_ADDR   = 8'h15;
  localparam int unsigned CAL_WORDS       = 15;
  localparam logic [7:0]  BURN_CMD_ADDR   = 8'h78;
  localparam logic [7:0]  RELOAD_CMD_ADDR = 8'h79;
  localparam int unsigned MAX_BURNS       = 6;
  localparam logic [2:0]  BURN_CNT_MAX    = 3'h6;
  localparam int unsigned BURN_WAIT_MS    = 20;
  // fault flag must settle before the host's 20 ms wait ends: finish at half of it
  localparam int unsigned BURN_CYCLES     = (CLK_HZ / 1000) * BURN_WAIT_MS / 2;
  localparam int unsigned REFRESH_MS      = 250;
  localparam int unsigned REFRESH_CYCLES  = (CLK_HZ / 1000) * REFRESH_MS;
  localparam int unsigned AUTO_REFRESH_BIT = 7;
  localparam logic [7:0]  AUTO_REFRESH_REG = 8'h07;
  typedef enum logic [1:0] {NVC_IDLE, NVC_BURN, NVC_RELOAD} nvc_state_t;
endpackage

/* rtl/nvc_programmer.sv */
// Purpose: stores calibration registers in non-volatile memory, reloads them, refreshes them
// Assumes: a serial slave delivers write and read strobes with address and data on clk
// Notes: nonvolatile array modelled as flops; programming supply pin is an input, synchronized and checked per burn
`timescale 1ns/1ps
`default_nettype none
module nvc_programmer
  import nvc_pkg::*;
#(
  parameter int unsigned BURN_TICKS    = BURN_CYCLES,
  parameter int unsigned REFRESH_TICKS = REFRESH_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] wrData,
  input  wire logic       programming_supply_pin,
  output logic      [7:0] rdData,
  output logic            rdValid,
  output logic            nv_write_fault_flag,
  output logic            burnBusy,
  output logic      [2:0] burnCount,
  output logic            autoRefreshOn
);
  logic [7:0]  calReg [CAL_WORDS];
  logic [7:0]  nvMem  [CAL_WORDS];
  nvc_state_t  state;
  nvc_state_t  next_state;
  logic [31:0] burnTimer;
  logic [31:0] next_burnTimer;
  logic [31:0] refreshTimer;
  logic [31:0] next_refreshTimer;
  logic        supplySync1;
  logic        supplySync2;
  logic        supplyOkLatch;
  logic        next_supplyOk;
  logic        next_burnBusy;
  logic        next_flag;
  logic [2:0]  next_burnCount;

  function automatic logic inCal(input logic [7:0] a);
    return (a >= CAL_FIRST_ADDR) && (a <= CAL_LAST_ADDR);
  endfunction

  // request and event decode
  wire        calWr      = wrStrobe && inCal(regAddr) && (state != NVC_BURN);
  wire        burnReq    = wrStrobe && (regAddr == BURN_CMD_ADDR) && (state == NVC_IDLE);
  wire        reloadReq  = wrStrobe && (regAddr == RELOAD_CMD_ADDR) && (state == NVC_IDLE);
  wire        burnDone   = (state == NVC_BURN) && (burnTimer == 32'(BURN_TICKS - 1));
  wire        wornOut    = (burnCount >= BURN_CNT_MAX);
  wire        supplyGood = supplyOkLatch && supplySync2;
  // a failed burn leaves the memory alone and does not use up a write
  wire        burnPass   = burnDone && !wornOut && supplyGood;
  wire        refreshHit = autoRefreshOn && (refreshTimer == 32'(REFRESH_TICKS - 1));
  wire        copyBack   = (state == NVC_RELOAD) || refreshHit;
  wire [3:0]  wrIdx      = 4'(regAddr - CAL_FIRST_ADDR);
  wire [3:0]  autoIdx    = 4'(AUTO_REFRESH_REG - CAL_FIRST_ADDR);
  wire [7:0]  autoReg    = calReg[autoIdx];
  wire        next_auto  = autoReg[AUTO_REFRESH_BIT];
  wire [7:0]  readMux    = inCal(regAddr) ? calReg[wrIdx] : 8'h00;

  always_comb begin
    next_state = state;
    case (state)
      NVC_IDLE: begin
        if (burnReq) begin
          next_state = NVC_BURN;
        end else if (reloadReq) begin
          next_state = NVC_RELOAD;
        end
      end
      NVC_BURN: begin
        if (burnDone) begin
          next_state = NVC_IDLE;
        end
      end
      NVC_RELOAD: begin
        next_state = NVC_IDLE;
      end
      default: begin
        next_state = NVC_IDLE;
      end
    endcase
  end

  assign next_burnTimer    = (state == NVC_BURN) ? burnTimer + 32'h1 : '0;
  // the supply must hold for the whole burn; any dropout fails it
  assign next_supplyOk     = burnReq ? supplySync2 : ((state == NVC_BURN) ? supplyGood : supplyOkLatch);
  assign next_burnBusy     = (state == NVC_IDLE) ? burnReq : ((state == NVC_BURN) && !burnDone);
  assign next_flag         = burnDone ? !burnPass : nv_write_fault_flag;
  assign next_burnCount    = burnPass ? burnCount + 3'h1 : burnCount;
  assign next_refreshTimer = (!autoRefreshOn || refreshHit) ? '0 : refreshTimer + 32'h1;

  // supply pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supplySync1 <= 1'b0;
      supplySync2 <= 1'b0;
    end else begin
      supplySync1 <= programming_supply_pin;
      supplySync2 <= supplySync1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= NVC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burnTimer <= '0;
    end else begin
      burnTimer <= next_burnTimer;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supplyOkLatch <= 1'b0;
    end else begin
      supplyOkLatch <= next_supplyOk;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burnBusy <= 1'b0;
    end else begin
      burnBusy <= next_burnBusy;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nv_write_fault_flag <= 1'b0;
    end else begin
      nv_write_fault_flag <= next_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burnCount <= 3'h0;
    end else begin
      burnCount <= next_burnCount;
    end
  end

  // burn snapshot and reload act on all words together
  genvar i;
  generate
    for (i = 0; i < CAL_WORDS; i++) begin : g_word
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          nvMem[i] <= 8'h00;
        end else if (burnPass) begin
          nvMem[i] <= calReg[i];
        end
      end

      // refresh and reload win over a host write in the same cycle
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          calReg[i] <= 8'h00;
        end else if (copyBack) begin
          calReg[i] <= nvMem[i];
        end else if (calWr && wrIdx == 4'(i)) begin
          calReg[i] <= wrData;
        end
      end
    end
  endgenerate

  // reset clears the live copy; reload after power-up is a host command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refreshTimer <= '0;
    end else begin
      refreshTimer <= next_refreshTimer;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      autoRefreshOn <= 1'b0;
    end else begin
      autoRefreshOn <= next_auto;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdStrobe;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      rdData <= readMux;
    end
  end
endmodule // nvc_programmer
`default_nettype wire

/* test/nvc_host_model.sv */
// Purpose: serial host driving register writes and reads
// Assumes: one-cycle strobes launched at the falling edge
// Notes: a released bus shows the inverse so stale values cannot match
`timescale 1ns/1ps
`default_nettype none
module nvc_host_model (
  input wire logic       clk,
  input wire logic [7:0] rdData,
  output var logic       wrStrobe,
  output var logic       rdStrobe,
  output var logic [7:0] regAddr,
  output var logic [7:0] wrData
);
  initial {wrStrobe, rdStrobe, regAddr, wrData} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) {regAddr, wrData, wrStrobe} = {a, d, 1'b1};
    @(negedge clk) {regAddr, wrData, wrStrobe} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {regAddr, rdStrobe} = {a, 1'b1};
    @(negedge clk) {regAddr, rdStrobe} = {~a, 1'b0};
    d = rdData;
  endtask
endmodule // nvc_host_model
`default_nettype wire

/* test/nvc_programmer_asserts.sv */
// Purpose: port checks for nvc_programmer
// Assumes: BURN_TICKS handed on from the instance
// Notes: ports grouped to keep the file short
`timescale 1ns/1ps
`default_nettype none
module nvc_programmer_checker
  import nvc_pkg::*;
#(
  parameter int unsigned BURN_TICKS = 20
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire logic       programming_supply_pin,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic       rdValid,
  input wire logic       nv_write_fault_flag,
  input wire logic       burnBusy,
  input wire logic       autoRefreshOn,
  input wire logic [2:0] burnCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  int unsigned busyLen;
  always_ff @(posedge clk) busyLen <= (sys_rst || !burnBusy) ? 0 : busyLen + 1;
  rd_answer_a: assert property (rdStrobe |=> rdValid) else $error("read unanswered");
  rd_cause_a: assert property (rdValid |-> $past(rdStrobe)) else $error("stray valid");
  rd_outside_a: assert property (rdValid && $past(regAddr) > CAL_LAST_ADDR |-> rdData == 8'h00)
    else $error("bad read");
  burn_start_a: assert property (wrStrobe && regAddr == BURN_CMD_ADDR && !burnBusy && programming_supply_pin
    && burnCount != BURN_CNT_MAX |=> burnBusy) else $error("no burn");
  burn_len_a: assert property ($fell(burnBusy) |-> busyLen == BURN_TICKS) else $error("burn length");
  cnt_cap_a: assert property (burnCount <= BURN_CNT_MAX) else $error("count cap");
  cnt_step_a: assert property ($changed(burnCount) |-> $fell(burnBusy) && burnCount == $past(burnCount) + 3'h1)
    else $error("count step");
  worn_out_a: assert property ($fell(burnBusy) && $past(burnCount) == BURN_CNT_MAX |-> nv_write_fault_flag)
    else $error("worn burn ok");
endmodule // nvc_programmer_checker
bind nvc_programmer nvc_programmer_checker #(.BURN_TICKS(BURN_TICKS)) u_chk (.*);
`default_nettype wire

/* test/testbench.sv */
// Purpose: self-checking bench for nvc_programmer
// Assumes: shortened burn and refresh counts
// Notes: the host model owns the serial side
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned BT = 20;
  logic       clk = 1'b0, sys_rst = 1'b1, supply = 1'b1, wrStrobe, rdStrobe, rdValid, flag, burnBusy, autoRefreshOn;
  logic [7:0] regAddr, wrData, rdData, v;
  logic [2:0] burnCount;
  int         miscompares = 0, comparisons = 0;
  always #25 clk = ~clk;
  nvc_programmer #(.BURN_TICKS(BT), .REFRESH_TICKS(50)) i_nvc_programmer (.clk, .sys_rst, .wrStrobe, .rdStrobe,
    .regAddr, .wrData, .programming_supply_pin(supply), .rdData, .rdValid, .nv_write_fault_flag(flag), .burnBusy,
    .burnCount, .autoRefreshOn);
  nvc_host_model i_nvc_host_model (.clk, .rdData, .wrStrobe, .rdStrobe, .regAddr, .wrData);
  task automatic chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic burn(input logic expFlag, input logic [2:0] expCnt);
    // burn data has four ones so the transfer parity stays even
    i_nvc_host_model.wr(8'h78, 8'hC3);
    chk(8'(burnBusy), 8'h01);
    repeat (BT + 3) @(negedge clk);
    chk(8'(burnBusy), 8'h00);
    chk(8'(flag), 8'(expFlag));
    chk(8'(burnCount), 8'(expCnt));
  endtask
  task automatic t_basic;
    for (int i = 0; i < 15; i++) i_nvc_host_model.wr(8'(8'h07 + i), 8'(8'h20 + i));
    burn(1'b0, 3'h1);
    i_nvc_host_model.wr(8'h15, 8'h99);
    i_nvc_host_model.wr(8'h79, 8'h00);
    i_nvc_host_model.rd(8'h15, v);
    chk(v, 8'h2E);
    i_nvc_host_model.rd(8'h30, v);
    chk(v, 8'h00);
    $display("done basic");
  endtask
  task automatic t_retry_wear;
    supply = 1'b0;
    burn(1'b1, 3'h1);
    supply = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 2; k <= 6; k++) burn(1'b0, 3'(k));
    burn(1'b1, 3'h6);
    $display("done retry and wear");
  endtask
  task automatic t_refresh;
    i_nvc_host_model.wr(8'h08, 8'h5A);
    i_nvc_host_model.wr(8'h07, 8'hA0);
    @(negedge clk);
    chk(8'(autoRefreshOn), 8'h01);
    for (int k = 0; k < 80 && v !== 8'h21; k++) i_nvc_host_model.rd(8'h08, v);
    chk(v, 8'h21);
    // restage with the refresh bit kept, burn and wait well inside the deadline
    i_nvc_host_model.wr(8'h07, 8'hA0);
    burn(1'b1, 3'h6);
    // a worn memory fails again; the retry starts from staging
    i_nvc_host_model.wr(8'h07, 8'hA0);
    burn(1'b1, 3'h6);
    i_nvc_host_model.wr(8'h79, 8'h00);
    i_nvc_host_model.rd(8'h08, v);
    chk(v, 8'h21);
    $display("done refresh");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_basic();
    t_retry_wear();
    t_refresh();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
